// >>> core/bacs_pkg.sv
`default_nettype none
package bacs_pkg;
    localparam int WORD_BITS = 24;
    localparam int WORD_CYCLES_DEF = 81920;
    localparam int BUF_DEPTH = 2;
    localparam int CAL_COUNT = 4;
    localparam logic [4:0] CMD_BITS = 5'h08;
    localparam logic [4:0] LAST_WRITE_CNT = 5'h18;
    localparam logic [4:0] LAST_READ_CNT = 5'h17;
    localparam int CMD_READ_BIT = 7;
    localparam logic [2:0] ADDR_CONFIG = 3'h0;
    localparam logic [2:0] ADDR_CAL_FIRST = 3'h1;
    localparam logic [2:0] ADDR_CAL_LAST = 3'h4;
    localparam logic [2:0] ADDR_DATA = 3'h7;
    localparam logic [23:0] CFG_RESET = 24'h00_0000;
    localparam logic [23:0] CAL_DEFAULT = 24'h40_0000;
    localparam logic signed [23:0] SAT_HI_U20 = 24'sh0F_FFFF;
    localparam logic signed [23:0] SAT_HI_U16 = 24'sh00_FFFF;
    localparam logic signed [23:0] SAT_HI_B20 = 24'sh07_FFFF;
    localparam logic signed [23:0] SAT_HI_B16 = 24'sh00_7FFF;
    localparam logic signed [23:0] SAT_LO_B20 = 24'shF8_0000;
    localparam logic signed [23:0] SAT_LO_B16 = 24'shFF_8000;
    localparam logic signed [23:0] SAT_LO_U = 24'sh00_0000;

    typedef struct packed {
        logic csN;
        logic sclk;
        logic sdi;
        logic mode;
    } bacs_pins_t;

    localparam bacs_pins_t PINS_IDLE = 4'h8;

    typedef struct packed {
        logic [19:0] spare;
        logic res20Sel;
        logic bipolarSel;
        logic sleepSel;
        logic filterRestartBit;
    } bacs_cfg_t;

    typedef enum logic [1:0] {
        ST_CMD,
        ST_WRITE,
        ST_WAIT,
        ST_SHIFT
    } bacs_state_t;
endpackage
`default_nettype wire

// >>> core/bacs_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module bacs_buffer #(
    parameter int WIDTH = bacs_pkg::WORD_BITS,
    parameter int DEPTH = bacs_pkg::BUF_DEPTH
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] memQ [DEPTH];
    logic [PW-1:0] wrPtrQ, rdPtrQ;
    logic [PW:0] countQ;
    logic push, pop;

    assign inReady = (countQ != (PW+1)'(DEPTH));
    assign outValid = (countQ != '0);
    assign outData = memQ[rdPtrQ];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Pointers wrap by hand so a depth that is not a power of two works.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wrPtrQ <= '0;
            rdPtrQ <= '0;
            countQ <= '0;
        end else begin
            if (push) begin
                wrPtrQ <= (wrPtrQ == PW'(DEPTH-1)) ? '0 : wrPtrQ + 1'b1;
            end
            if (pop) begin
                rdPtrQ <= (rdPtrQ == PW'(DEPTH-1)) ? '0 : rdPtrQ + 1'b1;
            end
            countQ <= countQ + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            memQ[wrPtrQ] <= inData;
        end
    end

    overflow_a: assert property (@(posedge ref_clk) disable iff (srst)
        (countQ == (PW+1)'(DEPTH)) |-> !inReady)
        else $error("buffer accepts a word while full");
endmodule // bacs_buffer
`default_nettype wire

// >>> core/bacs_control.sv
`timescale 1ns/1ps
`default_nettype none
module bacs_control #(
    parameter int WORD_CYCLES = bacs_pkg::WORD_CYCLES_DEF
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire bacs_pkg::bacs_pins_t pins,
    input wire logic signed [23:0] sampleIn,
    output logic serialDataOut,
    output logic serialDataOutOeN,
    output logic dataReadyN,
    output logic powerDown,
    output logic filterStart
);
    import bacs_pkg::*;

    localparam logic [16:0] WORD_LAST = 17'(WORD_CYCLES - 1);

    bacs_pins_t pinSync1Q, pinSync2Q;
    logic sclkPrevQ;
    bacs_state_t stateQ, stateD;
    logic [4:0] bitCntQ, bitCntD;
    logic [23:0] shiftInQ, shiftInD;
    logic [23:0] shiftOutQ, shiftOutD;
    logic [7:0] cmdQ, cmdD;
    logic drdyNQ, drdyND;
    bacs_cfg_t cfgQ;
    logic [23:0] calQ [CAL_COUNT];
    logic [16:0] wordCntQ;
    logic sodOeNQ, powerDownQ, filterStartQ;

    logic selected, sclkRise, sclkFall;
    logic cmdDone, writeEnd, readEnd, commitCfg;
    logic [2:0] cmdAddrIn;
    logic [23:0] regWord;
    bacs_cfg_t newCfg;
    logic filterRun, wordDone;
    logic bufInValid, bufInReady, bufOutValid, bufOutReady;
    logic [23:0] pushWord, bufOutData;

    function automatic logic isCalAddr(input logic [2:0] a);
        return (a >= ADDR_CAL_FIRST) && (a <= ADDR_CAL_LAST);
    endfunction

    function automatic logic [1:0] calIndex(input logic [2:0] a);
        return a[1:0] - 2'h1;
    endfunction

    function automatic logic [23:0] codeWord(
        input logic signed [23:0] s,
        input logic bip,
        input logic res20
    );
        logic signed [23:0] v, hi, lo, sat;
        logic over;
        v = res20 ? s : (s >>> 4);
        hi = bip ? (res20 ? SAT_HI_B20 : SAT_HI_B16)
                 : (res20 ? SAT_HI_U20 : SAT_HI_U16);
        lo = bip ? (res20 ? SAT_LO_B20 : SAT_LO_B16) : SAT_LO_U;
        over = (v > hi) || (v < lo);
        sat = (v > hi) ? hi : ((v < lo) ? lo : v);
        if (res20) begin
            return {sat[19:0], {4{over}}};
        end
        return {sat[15:0], {8{over}}};
    endfunction

    // Every pin is foreign to ref_clk and passes two flops first.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pinSync1Q <= PINS_IDLE;
            pinSync2Q <= PINS_IDLE;
            sclkPrevQ <= 1'b0;
        end else begin
            pinSync1Q <= pins;
            pinSync2Q <= pinSync1Q;
            sclkPrevQ <= pinSync2Q.sclk;
        end
    end

    // In three wire mode chip select is not looked at.
    assign selected = pinSync2Q.mode | ~pinSync2Q.csN;
    assign sclkRise = selected & pinSync2Q.sclk & ~sclkPrevQ;
    assign sclkFall = selected & ~pinSync2Q.sclk & sclkPrevQ;

    assign cmdDone = (stateQ == ST_CMD) && sclkFall && (bitCntQ == CMD_BITS);
    assign writeEnd = (stateQ == ST_WRITE) && sclkFall
        && (bitCntQ == LAST_WRITE_CNT);
    assign readEnd = (stateQ == ST_SHIFT) && sclkFall
        && (bitCntQ == LAST_READ_CNT);
    assign commitCfg = writeEnd && (cmdQ[2:0] == ADDR_CONFIG);
    assign newCfg = bacs_cfg_t'(shiftInQ);
    assign cmdAddrIn = shiftInQ[2:0];
    assign regWord = (cmdAddrIn == ADDR_CONFIG) ? 24'(cfgQ)
        : (isCalAddr(cmdAddrIn) ? calQ[calIndex(cmdAddrIn)] : 24'h00_0000);

    always_comb begin
        stateD = stateQ;
        bitCntD = bitCntQ;
        shiftInD = shiftInQ;
        shiftOutD = shiftOutQ;
        cmdD = cmdQ;
        drdyND = drdyNQ;
        bufOutReady = 1'b0;
        case (stateQ)
            ST_CMD: begin
                // The data pin is sampled on rising clocks only.
                if (sclkRise && (bitCntQ != CMD_BITS)) begin
                    shiftInD = {shiftInQ[22:0], pinSync2Q.sdi};
                    bitCntD = bitCntQ + 5'h01;
                end
                if (cmdDone) begin
                    cmdD = shiftInQ[7:0];
                    bitCntD = 5'h00;
                    if (!shiftInQ[CMD_READ_BIT]) begin
                        stateD = ST_WRITE;
                    end else if (cmdAddrIn == ADDR_DATA) begin
                        stateD = ST_WAIT;
                    end else begin
                        stateD = ST_SHIFT;
                        shiftOutD = regWord;
                    end
                end
            end
            ST_WRITE: begin
                if (sclkRise && (bitCntQ != LAST_WRITE_CNT)) begin
                    shiftInD = {shiftInQ[22:0], pinSync2Q.sdi};
                    bitCntD = bitCntQ + 5'h01;
                end
                if (writeEnd) begin
                    stateD = ST_CMD;
                    bitCntD = 5'h00;
                end
            end
            ST_WAIT: begin
                // Dropping select frees a host that gave up waiting.
                if (!selected) begin
                    stateD = ST_CMD;
                end else if (bufOutValid) begin
                    bufOutReady = 1'b1;
                    shiftOutD = bufOutData;
                    drdyND = 1'b0;
                    stateD = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (readEnd) begin
                    stateD = ST_CMD;
                    bitCntD = 5'h00;
                    shiftOutD = 24'h00_0000;
                    drdyND = 1'b1;
                end else if (sclkFall) begin
                    shiftOutD = {shiftOutQ[22:0], 1'b0};
                    bitCntD = bitCntQ + 5'h01;
                end
            end
            default: begin
                stateD = ST_CMD;
                bitCntD = 5'h00;
            end
        endcase
        if (cfgQ.sleepSel || cfgQ.filterRestartBit) begin
            drdyND = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stateQ <= ST_CMD;
            bitCntQ <= 5'h00;
            shiftInQ <= 24'h00_0000;
            shiftOutQ <= 24'h00_0000;
            cmdQ <= 8'h00;
            drdyNQ <= 1'b1;
        end else begin
            stateQ <= stateD;
            bitCntQ <= bitCntD;
            shiftInQ <= shiftInD;
            shiftOutQ <= shiftOutD;
            cmdQ <= cmdD;
            drdyNQ <= drdyND;
        end
    end

    // Registers change only at the fall that ends a whole word.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfgQ <= CFG_RESET;
            for (int i = 0; i < CAL_COUNT; i++) begin
                calQ[i] <= CAL_DEFAULT;
            end
        end else if (writeEnd) begin
            if (cmdQ[2:0] == ADDR_CONFIG) begin
                cfgQ <= newCfg;
            end else if (isCalAddr(cmdQ[2:0])) begin
                calQ[calIndex(cmdQ[2:0])] <= shiftInQ;
            end
        end
    end

    // The halted counter sits at zero, so a restart lines up words.
    assign filterRun = !cfgQ.filterRestartBit && !cfgQ.sleepSel;
    assign wordDone = filterRun && (wordCntQ == WORD_LAST);
    assign bufInValid = wordDone;
    assign pushWord = codeWord(sampleIn, cfgQ.bipolarSel,
        cfgQ.res20Sel);

    always_ff @(posedge ref_clk) begin
        if (srst || commitCfg || !filterRun) begin
            wordCntQ <= 17'h0_0000;
        end else if (!wordDone) begin
            wordCntQ <= wordCntQ + 17'h0_0001;
        end else if (bufInReady) begin
            wordCntQ <= 17'h0_0000;
        end
    end

    // A full buffer stalls the filter at its last count, losing no word.
    bacs_buffer #(
        .WIDTH(WORD_BITS),
        .DEPTH(BUF_DEPTH)
    ) wordBuf (
        .ref_clk(ref_clk),
        .srst(srst),
        .inValid(bufInValid),
        .inReady(bufInReady),
        .inData(pushWord),
        .outValid(bufOutValid),
        .outReady(bufOutReady),
        .outData(bufOutData)
    );

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sodOeNQ <= 1'b1;
            powerDownQ <= 1'b0;
            filterStartQ <= 1'b0;
        end else begin
            sodOeNQ <= ~selected;
            powerDownQ <= cfgQ.sleepSel;
            filterStartQ <= commitCfg && !newCfg.filterRestartBit
                && !newCfg.sleepSel;
        end
    end

    assign serialDataOut = shiftOutQ[23];
    assign serialDataOutOeN = sodOeNQ;
    assign dataReadyN = drdyNQ;
    assign powerDown = powerDownQ;
    assign filterStart = filterStartQ;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    sequence cfgGo_s;
        commitCfg && !newCfg.filterRestartBit && !newCfg.sleepSel;
    endsequence

    sequence countFromZero_s;
        (filterStartQ && wordCntQ == 17'h0_0000) ##1
            (wordCntQ == 17'h0_0001);
    endsequence

    sequence lastFall_s;
        readEnd;
    endsequence

    sequence idleReleased_s;
        dataReadyN && (stateQ == ST_CMD);
    endsequence

    property reset_state_p;
        $fell(srst) |-> (stateQ == ST_CMD) && !cfgQ.sleepSel
            && (bitCntQ == 5'h00);
    endproperty

    reset_port_a: assert property (reset_state_p)
        else $error("reset left port or sleep bit wrong");

    cal_default_a: assert property (
        $fell(srst) |-> (calQ[0] == CAL_DEFAULT)
            && (calQ[CAL_COUNT-1] == CAL_DEFAULT))
        else $error("calibration default missing after reset");

    write_hold_a: assert property (
        ((stateQ == ST_WRITE) && !writeEnd) |=> $stable(cfgQ))
        else $error("config changed before 24th falling clock");

    restart_go_a: assert property (
        cfgGo_s |=> countFromZero_s)
        else $error("filter did not restart after config write");

    halt_hold_a: assert property (
        cfgQ.filterRestartBit |-> !bufInValid && (wordCntQ == 17'h0_0000)
            ##1 dataReadyN)
        else $error("word or ready issued while halted");

    word_period_a: assert property (
        (wordDone && bufInReady && !commitCfg) |=>
            (wordCntQ == 17'h0_0000) ##1 (wordCntQ == 17'h0_0001))
        else $error("word period counter did not wrap");

    uni_sat_a: assert property (
        (bufInValid && !cfgQ.bipolarSel && cfgQ.res20Sel
            && sampleIn > SAT_HI_U20) |-> (pushWord == 24'hFF_FFFF))
        else $error("unipolar overrange not all ones with flags");

    bip_sat_a: assert property (
        (bufInValid && cfgQ.bipolarSel && !cfgQ.res20Sel
            && (sampleIn >>> 4) < SAT_LO_B16) |->
            (pushWord == 24'h80_00FF))
        else $error("bipolar negative saturation wrong");

    msb_shift_a: assert property (
        ((stateQ == ST_SHIFT) && sclkFall && !readEnd) |=>
            (serialDataOut == $past(shiftOutQ[22])))
        else $error("serial output did not advance one bit");

    ready_end_a: assert property (
        lastFall_s |=> idleReleased_s)
        else $error("data ready not raised after last bit");

    sleep_ready_a: assert property (
        cfgQ.sleepSel |=> dataReadyN && powerDown)
        else $error("sleep did not power down or raise ready");

    float_out_a: assert property (
        (pinSync2Q.csN && !pinSync2Q.mode) |=> serialDataOutOeN)
        else $error("serial output driven while deselected");

    three_wire_a: assert property (
        pinSync2Q.mode |=> !serialDataOutOeN)
        else $error("three wire mode did not drive output");

    deselect_quiet_a: assert property (
        (!selected && stateQ != ST_WAIT) |=> $stable(bitCntQ)
            && $stable(shiftInQ))
        else $error("port moved while deselected");
endmodule // bacs_control
`default_nettype wire

// >>> verification/bacs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bacs_host_model (
    input wire logic ref_clk,
    input wire logic serialDataOut,
    input wire logic dataReadyN,
    output var bacs_pkg::bacs_pins_t pins
);
    import bacs_pkg::*;

    // The host runs from the device's master clock, so pin moves follow it.
    initial begin
        pins = PINS_IDLE;
    end

    // One frame, command then data, MSB first; nBits below 32 cuts it short.
    task automatic frame(input logic [7:0] cmd, input logic [23:0] dat,
        input logic sel, input logic md, input int nBits,
        output logic [23:0] rd);
        logic [31:0] word;
        int guard;
        word = {cmd, dat};
        rd = '0;
        guard = 0;
        @(posedge ref_clk);
        pins.csN <= sel;
        pins.mode <= md;
        for (int i = 31; i >= 32 - nBits; i--) begin
            pins.sdi <= word[i];
            repeat (4) @(posedge ref_clk);
            pins.sclk <= 1'h1;
            repeat (4) @(posedge ref_clk);
            if (i < 24) begin
                rd = {rd[22:0], serialDataOut};
            end
            pins.sclk <= 1'h0;
            // A data read stalls until a word is loaded into the port.
            if (i == 24 && cmd == 8'h87) begin
                while (dataReadyN !== 1'h0 && guard < 400) begin
                    @(posedge ref_clk);
                    guard++;
                end
            end
        end
        repeat (4) @(posedge ref_clk);
        pins.csN <= 1'h1;
        pins.mode <= 1'h0;
        // A released data line must not keep showing its last value.
        pins.sdi <= ~pins.sdi;
    endtask
endmodule // bacs_host_model
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("ERROR %s expected %h seen %h", nm, exp, got); \
        end \
    end
module tb_top;
    import bacs_pkg::*;
    localparam int WC = 64;
    logic ref_clk = 1'h0;
    logic srst = 1'h1;
    logic signed [23:0] sampleIn = '0;
    bacs_pins_t pins;
    logic serialDataOut;
    logic serialDataOutOeN;
    logic dataReadyN;
    logic powerDown;
    logic filterStart;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    int starts = 0;
    logic [23:0] rd;
    localparam logic [3:0] CFGS [9] = '{4'h0, 4'h0, 4'h0, 4'h4, 4'h4,
        4'hC, 4'hC, 4'h8, 4'h8};
    localparam logic [23:0] SMPS [9] = '{24'h12_3450, 24'hFF_FFF0,
        24'h01_2340, 24'h10_0000, 24'hF0_0000, 24'h10_0000, 24'hF0_0000,
        24'h20_0000, 24'h0A_BCDE};
    localparam logic [23:0] EXPS [9] = '{24'hFF_FFFF, 24'h00_00FF,
        24'h12_3400, 24'h7F_FFFF, 24'h80_00FF, 24'h7F_FFFF, 24'h80_000F,
        24'hFF_FFFF, 24'hAB_CDE0};

    bacs_control #(.WORD_CYCLES(WC)) u_bacs_control (
        .ref_clk(ref_clk), .srst(srst), .pins(pins), .sampleIn(sampleIn),
        .serialDataOut(serialDataOut), .serialDataOutOeN(serialDataOutOeN),
        .dataReadyN(dataReadyN), .powerDown(powerDown),
        .filterStart(filterStart)
    );
    bacs_host_model u_bacs_host_model (
        .ref_clk(ref_clk), .serialDataOut(serialDataOut),
        .dataReadyN(dataReadyN), .pins(pins)
    );

    always #25 ref_clk = ~ref_clk;

    // The ceiling is nearly three times the expected run, so a stall ends cleanly.
    always @(posedge ref_clk) begin
        cycles++;
        if (filterStart === 1'h1) starts++;
        if (cycles == 40000) begin
            failures++;
            summarize();
        end
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        srst <= 1'h1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'h0;
    endtask

    task automatic wr(input logic [2:0] a, input logic [23:0] d);
        logic [23:0] unused;
        u_bacs_host_model.frame({5'h00, a}, d, 1'h0, 1'h0, 32, unused);
    endtask

    task automatic rdr(input logic [2:0] a, output logic [23:0] q);
        u_bacs_host_model.frame({5'h10, a}, 24'hA5_A5A5, 1'h0, 1'h0, 32, q);
    endtask

    task automatic t_reset();
        `CHK("sleep after reset", 1'h0, powerDown)
        `CHK("output float", 1'h1, serialDataOutOeN)
        for (int a = 1; a <= 4; a++) begin
            rdr(3'(a), rd);
            `CHK("cal default", CAL_DEFAULT, rd)
        end
        wr(3'h1, 24'h12_3456);
        rdr(3'h1, rd);
        `CHK("cal readback", 24'h12_3456, rd)
        u_bacs_host_model.frame(8'h81, 24'h00_0000, 1'h0, 1'h0, 5, rd);
        do_reset();
        rdr(3'h1, rd);
        `CHK("cal after reset", CAL_DEFAULT, rd)
        $display("test reset done");
    endtask

    task automatic t_select();
        u_bacs_host_model.frame(8'h02, 24'hAB_CDEF, 1'h1, 1'h0, 32, rd);
        repeat (5) @(posedge ref_clk);
        `CHK("idle float", 1'h1, serialDataOutOeN)
        rdr(3'h2, rd);
        `CHK("deselected write", CAL_DEFAULT, rd)
        u_bacs_host_model.frame(8'h02, 24'hAB_CDEF, 1'h1, 1'h1, 32, rd);
        rdr(3'h2, rd);
        `CHK("three wire write", 24'hAB_CDEF, rd)
        $display("test select done");
    endtask

    task automatic t_restart();
        int s;
        wr(ADDR_CONFIG, 24'h00_0001);
        s = starts;
        repeat (3 * WC) @(posedge ref_clk);
        `CHK("halted starts", s, starts)
        `CHK("halted ready", 1'h1, dataReadyN)
        wr(ADDR_CONFIG, 24'h00_0000);
        repeat (4) @(posedge ref_clk);
        `CHK("restart pulse", s + 1, starts)
        $display("test restart done");
    endtask

    task automatic t_sleep();
        int s;
        wr(ADDR_CONFIG, 24'h00_0002);
        repeat (4) @(posedge ref_clk);
        `CHK("sleep", 1'h1, powerDown)
        s = starts;
        repeat (3 * WC) @(posedge ref_clk);
        `CHK("sleep starts", s, starts)
        `CHK("sleep ready", 1'h1, dataReadyN)
        wr(ADDR_CONFIG, 24'h00_0001);
        repeat (4) @(posedge ref_clk);
        `CHK("wake", 1'h0, powerDown)
        wr(ADDR_CONFIG, 24'h00_0000);
        repeat (6 * WC) @(posedge ref_clk);
        $display("test sleep done");
    endtask

    task automatic t_coding();
        for (int k = 0; k < 9; k++) begin
            @(posedge ref_clk);
            sampleIn <= SMPS[k];
            wr(ADDR_CONFIG, {20'h0_0000, CFGS[k]});
            // Two buffered words may predate the change; the third is fresh.
            repeat (3) rdr(ADDR_DATA, rd);
            `CHK("coded word", EXPS[k], rd)
            `CHK("ready after read", 1'h1, dataReadyN)
        end
        $display("test coding done");
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'h0;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_select();
        t_restart();
        t_sleep();
        t_coding();
        summarize();
    end
endmodule // tb_top
`default_nettype wire
